// ==== quad_pot_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
// *****
// port checker
// *****
module quad_pot_chk import quad_pot_pkg::*; (
	// clock, reset and link clock
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic sclClk,
	// two-wire pins
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic [STRAP_W-1:0] strapAddr,
	// up/down pins
	input wire logic csN,
	input wire logic upDir,
	input wire logic [CHAN_W-1:0] chanSel,
	input wire logic wpN,
	// wiper state
	input wire logic [NUM_CHAN-1:0][POS_W-1:0] wiperPos,
	input wire logic [NUM_CHAN-1:0][NUM_TAPS-1:0] tapClosed,
	input wire logic linkBusy
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// select held low long enough for the synchroniser
	sequence stepMode;
		(!csN) [*6];
	endsequence
	sequence serialMode;
		csN [*8];
	endsequence
	chk_sda_low: assert property (sdaOut == SDA_DRIVE_LEVEL) else $error("data driven high");
	chk_cs_quiet: assert property (stepMode |-> !sdaOe && !linkBusy) else $error("serial active");
	chk_oe_busy: assert property (sdaOe |-> linkBusy && csN) else $error("pull while idle");
	chk_recall_dflt: assert property ($rose(nrst) |-> ##[1:2] wiperPos == {NUM_CHAN{NV_INIT}})
		else $error("no recall");
	chk_sda_edge: assert property ($changed(sdaOe) |-> !sclClk && !$past(sclClk) && !$past(sclClk, 2))
		else $error("data moved, clock high");
	// the recall right after reset release is not a serial change
	chk_wiper_quiet: assert property (serialMode ##0 !linkBusy && !$past(linkBusy) && $past(nrst, 2)
		|-> $stable(wiperPos)) else $error("wiper moved while idle");
	for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
		// tap switch follows wiper one cycle later
		chk_tap_onehot: assert property ($past(nrst)
			|-> tapClosed[c] == (NUM_TAPS'(1) << $past(wiperPos[c]))) else $error("tap wrong");
		// one tap per step, on the selected channel, in the set direction
		chk_step_dir: assert property (stepMode ##0 $changed(wiperPos[c])
			|-> chanSel == CHAN_W'(c)
			&& wiperPos[c] == (upDir ? $past(wiperPos[c]) + POS_ONE : $past(wiperPos[c]) - POS_ONE))
			else $error("bad step");
		chk_step_sat: assert property (stepMode ##0
			$past(wiperPos[c]) == (upDir ? POS_MAX : POS_MIN) |-> $stable(wiperPos[c]))
			else $error("wiper wrapped");
	end
endmodule // quad_pot_chk
bind quad_pot_wiper_control quad_pot_chk u_chk (.clk_sys(clk_sys), .nrst(nrst), .sclClk(sclClk),
	.sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .strapAddr(strapAddr), .csN(csN), .upDir(upDir),
	.chanSel(chanSel), .wpN(wpN), .wiperPos(wiperPos), .tapClosed(tapClosed), .linkBusy(linkBusy));
`default_nettype wire

// ==== quad_pot_pkg.sv ====
`default_nettype none
package quad_pot_pkg;

	// ***********************************************
	// channel and storage geometry
	// ***********************************************
	localparam int NUM_CHAN = 4;
	localparam int CHAN_W = 2;
	localparam int NUM_SLOT = 4;
	localparam int SLOT_W = 2;
	localparam int POS_W = 8;
	localparam int NUM_TAPS = 256;
	localparam int STRAP_W = 3;

	// ***********************************************
	// wiper limits and reset values
	// ***********************************************
	localparam logic [POS_W-1:0] POS_MAX = 8'hFF;
	localparam logic [POS_W-1:0] POS_MIN = 8'h00;
	localparam logic [POS_W-1:0] POS_ONE = 8'h01;
	localparam logic [POS_W-1:0] NV_INIT = 8'h80;
	localparam logic [SLOT_W-1:0] DEFAULT_SLOT = 2'h0;

	// ***********************************************
	// two-wire framing
	// ***********************************************
	// fixed upper part of the slave address, value arbitrary
	localparam logic [4:0] DEV_ID_HI = 5'h0A;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic SDA_DRIVE_LEVEL = 1'b0;
	localparam logic [1:0] FIELD_ADDR = 2'h0;
	localparam logic [1:0] FIELD_OPC = 2'h1;
	localparam logic [1:0] FIELD_REGA = 2'h2;
	localparam logic [1:0] FIELD_DATA = 2'h3;
	localparam int OPC_LSB = 4;
	localparam int REGA_CHAN_LSB = 0;
	localparam int REGA_SLOT_LSB = 2;

	// ***********************************************
	// operation codes, upper nibble of the opcode byte
	// ***********************************************
	localparam logic [3:0] OP_RD_WIPER = 4'h9;
	localparam logic [3:0] OP_WR_WIPER = 4'hA;
	localparam logic [3:0] OP_RD_SAVED = 4'hB;
	localparam logic [3:0] OP_WR_SAVED = 4'hC;
	localparam logic [3:0] OP_XFR_TO_WIPER = 4'hD;
	localparam logic [3:0] OP_XFR_TO_SAVED = 4'hE;

	// ***********************************************
	// pin synchroniser layout
	// ***********************************************
	localparam int PIN_SYNC_W = 9;
	localparam int PIN_SCL = 8;
	localparam int PIN_SDA = 7;
	localparam int PIN_CS = 6;
	localparam int PIN_WP = 5;
	localparam int PIN_STRAP_LSB = 2;
	localparam int PIN_CHAN_LSB = 0;
	localparam logic [PIN_SYNC_W-1:0] PIN_SYNC_INIT = 9'h1E0;

	// two-wire slave states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RECV,
		ST_ACK,
		ST_SEND,
		ST_MACK
	} twi_state_e;

endpackage
`default_nettype wire

// ==== quad_pot_wiper_control.sv ====
//Behaviour
//- four channels, each with an eight-bit wiper position of 256 taps
//- wiper position drives a one-hot tap switch selection per channel
//- four saved positions per channel, writable and readable directly
//- after reset the first saved slot is copied into each wiper
//- serial link offers write, read and transfer operations
//- serial fields arrive as address, opcode, register address, data
//- serial input bits are taken at each rising clock edge
//- outgoing serial bits change only after a falling clock edge
//- data line is only pulled low or released; outside pull-up needed
//- strap inputs form low three address bits; respond only on match
//- select low: stepping allowed, serial link ignored
//- select high: serial link is the active control path
//- direction high steps up, low steps down
//- channel select picks the channel for stepping and storing
//- serial clock clocks both serial transfers and stepping
//- write-protect low blocks all saved-slot writes, serial and store
`timescale 1ns/100ps
`default_nettype none
module quad_pot_wiper_control import quad_pot_pkg::*; (
	// system clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// two-wire link pins
	input wire logic sclClk,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic [STRAP_W-1:0] strapAddr,
	// up/down link pins
	input wire logic csN,
	input wire logic upDir,
	input wire logic [CHAN_W-1:0] chanSel,
	input wire logic wpN,
	// wiper state
	output logic [NUM_CHAN-1:0][POS_W-1:0] wiperPos,
	output logic [NUM_CHAN-1:0][NUM_TAPS-1:0] tapClosed,
	output logic linkBusy
);

	// ***********************************************
	// helper functions
	// ***********************************************

	// one-hot tap switch for a wiper position
	function automatic logic [NUM_TAPS-1:0] tapDecode(input logic [POS_W-1:0] pos);
		logic [NUM_TAPS-1:0] t;
		t = '0;
		t[pos] = 1'b1;
		return t;
	endfunction

	// single saturating step
	function automatic logic [POS_W-1:0] satStep(input logic [POS_W-1:0] pos, input logic up);
		logic [POS_W-1:0] r;
		r = pos;
		if (up && pos != POS_MAX) begin
			r = pos + POS_ONE;
		end else if (!up && pos != POS_MIN) begin
			r = pos - POS_ONE;
		end
		return r;
	endfunction

	// ***********************************************
	// storage and link state
	// ***********************************************
	logic [NUM_CHAN-1:0][POS_W-1:0] wiper_q;
	logic [NUM_CHAN-1:0][NUM_SLOT-1:0][POS_W-1:0] saved_q;
	logic recall_q;
	twi_state_e state_q;
	twi_state_e nextSt_q;
	logic [1:0] field_q;
	logic [2:0] bitCnt_q;
	logic [POS_W-1:0] shift_q;
	logic [3:0] opc_q;
	logic [CHAN_W-1:0] regChan_q;
	logic [SLOT_W-1:0] regSlot_q;
	logic sdaLow_q;
	logic sclP_q;
	logic sdaP_q;
	logic csP_q;
	logic stepP_q;

	// ***********************************************
	// pin synchronisers and edge detection
	// ***********************************************
	logic [PIN_SYNC_W-1:0] pinRaw;
	logic [PIN_SYNC_W-1:0] pinSync;
	logic sclS, sdaS, csS, wpS;
	logic [STRAP_W-1:0] strapS;
	logic [CHAN_W-1:0] chanS;
	logic stepS;
	logic sclRise, sclFall, startEv, stopEv, storeEv, stepEv;
	step_if stepBus ();

	assign pinRaw = {sclClk, sdaIn, csN, wpN, strapAddr, chanSel};

	sync_2ff #(
		.WIDTH(PIN_SYNC_W),
		.RESET_VAL(PIN_SYNC_INIT)
	) u_pin_sync (
		.clk(clk_sys),
		.nrst(nrst),
		.din(pinRaw),
		.dout(pinSync)
	);

	// stepping runs on the link clock itself
	updown_stepper u_stepper (
		.sclClk(sclClk),
		.nrst(nrst),
		.csN(csN),
		.upDir(upDir),
		.chanSel(chanSel),
		.stepPort(stepBus.src)
	);

	// step toggle crosses into the system domain
	sync_2ff #(
		.WIDTH(1),
		.RESET_VAL(1'b0)
	) u_step_sync (
		.clk(clk_sys),
		.nrst(nrst),
		.din(stepBus.stepTgl),
		.dout(stepS)
	);

	// synchronised pin fields
	assign sclS = pinSync[PIN_SCL];
	assign sdaS = pinSync[PIN_SDA];
	assign csS = pinSync[PIN_CS];
	assign wpS = pinSync[PIN_WP];
	assign strapS = pinSync[PIN_STRAP_LSB +: STRAP_W];
	assign chanS = pinSync[PIN_CHAN_LSB +: CHAN_W];

	// previous samples for edge detection
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			sclP_q <= 1'b1;
			sdaP_q <= 1'b1;
			csP_q <= 1'b1;
			stepP_q <= 1'b0;
		end else begin
			sclP_q <= sclS;
			sdaP_q <= sdaS;
			csP_q <= csS;
			stepP_q <= stepS;
		end
	end

	// link events
	assign sclRise = sclS && !sclP_q;
	assign sclFall = !sclS && sclP_q;
	assign startEv = sclS && sclP_q && sdaP_q && !sdaS;
	assign stopEv = sclS && sclP_q && !sdaP_q && sdaS;
	assign storeEv = csS && !csP_q && sclS;
	assign stepEv = stepS ^ stepP_q;

	// ***********************************************
	// received byte decode
	// ***********************************************
	logic byteDone;
	logic accept;
	logic [POS_W-1:0] rxByte;
	logic [3:0] rxOpc;
	logic [CHAN_W-1:0] exeChan;
	logic [SLOT_W-1:0] exeSlot;
	logic [POS_W-1:0] rdData;
	logic opRead, opWrite, opXfr;
	logic twiWrWiper, twiWrSaved, xfrToWiper, xfrToSaved;
	twi_state_e afterAck;

	assign byteDone = (state_q == ST_RECV) && sclRise && (bitCnt_q == BIT_LAST);
	assign rxByte = {shift_q[POS_W-2:0], sdaS};
	assign rxOpc = rxByte[OPC_LSB +: 4];
	assign opRead = (opc_q == OP_RD_WIPER) || (opc_q == OP_RD_SAVED);
	assign opWrite = (opc_q == OP_WR_WIPER) || (opc_q == OP_WR_SAVED);
	assign opXfr = (opc_q == OP_XFR_TO_WIPER) || (opc_q == OP_XFR_TO_SAVED);

	// register address comes straight from the byte while it completes
	assign exeChan = (field_q == FIELD_REGA) ? rxByte[REGA_CHAN_LSB +: CHAN_W] : regChan_q;
	assign exeSlot = (field_q == FIELD_REGA) ? rxByte[REGA_SLOT_LSB +: SLOT_W] : regSlot_q;

	// read source for the outgoing byte
	assign rdData = (opc_q == OP_RD_WIPER) ? wiper_q[regChan_q] : saved_q[regChan_q][regSlot_q];

	// acceptance and follow-on state per field
	always_comb begin
		accept = 1'b1;
		afterAck = ST_IDLE;
		case (field_q)
			FIELD_ADDR: begin
				accept = (rxByte == {DEV_ID_HI, strapS});
				afterAck = ST_RECV;
			end
			FIELD_OPC: begin
				accept = (rxOpc >= OP_RD_WIPER) && (rxOpc <= OP_XFR_TO_SAVED);
				afterAck = ST_RECV;
			end
			FIELD_REGA: begin
				afterAck = opRead ? ST_SEND : (opWrite ? ST_RECV : ST_IDLE);
			end
			default: begin
				afterAck = ST_IDLE;
			end
		endcase
	end

	// operations executed when their last byte completes
	assign twiWrWiper = byteDone && (field_q == FIELD_DATA) && (opc_q == OP_WR_WIPER);
	assign twiWrSaved = byteDone && (field_q == FIELD_DATA) && (opc_q == OP_WR_SAVED)
		&& wpS;
	assign xfrToWiper = byteDone && (field_q == FIELD_REGA) && (opc_q == OP_XFR_TO_WIPER);
	assign xfrToSaved = byteDone && (field_q == FIELD_REGA) && (opc_q == OP_XFR_TO_SAVED)
		&& wpS;

	// ***********************************************
	// two-wire slave
	// ***********************************************

	// framing, acknowledge and transmit sequencing
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			nextSt_q <= ST_IDLE;
			field_q <= FIELD_ADDR;
			bitCnt_q <= BIT_FIRST;
			shift_q <= '0;
			sdaLow_q <= 1'b0;
		end else if (!csS) begin
			state_q <= ST_IDLE;
			sdaLow_q <= 1'b0;
		end else if (startEv) begin
			state_q <= ST_RECV;
			field_q <= FIELD_ADDR;
			bitCnt_q <= BIT_FIRST;
			sdaLow_q <= 1'b0;
		end else if (stopEv) begin
			state_q <= ST_IDLE;
			sdaLow_q <= 1'b0;
		end else begin
			case (state_q)
				ST_RECV: begin
					if (byteDone) begin
						state_q <= accept ? ST_ACK : ST_IDLE;
						nextSt_q <= afterAck;
						field_q <= field_q + 2'h1;
						bitCnt_q <= BIT_FIRST;
					end else if (sclRise) begin
						shift_q <= rxByte;
						bitCnt_q <= bitCnt_q + 3'h1;
					end
				end
				ST_ACK: begin
					if (sclFall && !sdaLow_q) begin
						sdaLow_q <= 1'b1;
					end else if (sclFall) begin
						state_q <= nextSt_q;
						bitCnt_q <= BIT_FIRST;
						shift_q <= rdData;
						sdaLow_q <= (nextSt_q == ST_SEND) ? ~rdData[POS_W-1] : 1'b0;
					end
				end
				ST_SEND: begin
					if (sclFall && bitCnt_q == BIT_LAST) begin
						state_q <= ST_MACK;
						sdaLow_q <= 1'b0;
					end else if (sclFall) begin
						shift_q <= {shift_q[POS_W-2:0], 1'b0};
						sdaLow_q <= ~shift_q[POS_W-2];
						bitCnt_q <= bitCnt_q + 3'h1;
					end
				end
				ST_MACK: begin
					if (sclRise) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
					sdaLow_q <= 1'b0;
				end
			endcase
		end
	end

	// opcode and register address capture
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			opc_q <= '0;
			regChan_q <= '0;
			regSlot_q <= DEFAULT_SLOT;
		end else if (byteDone && accept && field_q == FIELD_OPC) begin
			opc_q <= rxOpc;
		end else if (byteDone && field_q == FIELD_REGA) begin
			regChan_q <= exeChan;
			regSlot_q <= exeSlot;
		end
	end

	// data line only pulled low, never driven high
	assign sdaOut = SDA_DRIVE_LEVEL;
	assign sdaOe = sdaLow_q;
	assign linkBusy = (state_q != ST_IDLE);

	// ***********************************************
	// wiper and saved positions
	// ***********************************************

	// one recall cycle after reset release
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			recall_q <= 1'b1;
		end else begin
			recall_q <= 1'b0;
		end
	end

	// volatile wiper positions
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			for (int c = 0; c < NUM_CHAN; c++) begin
				wiper_q[c] <= POS_MIN;
			end
		end else if (recall_q) begin
			for (int c = 0; c < NUM_CHAN; c++) begin
				wiper_q[c] <= saved_q[c][DEFAULT_SLOT];
			end
		end else if (twiWrWiper) begin
			wiper_q[exeChan] <= rxByte;
		end else if (xfrToWiper) begin
			wiper_q[exeChan] <= saved_q[exeChan][exeSlot];
		end else if (stepEv) begin
			wiper_q[stepBus.stepChan] <= satStep(wiper_q[stepBus.stepChan],
				stepBus.stepUp);
		end
	end

	// saved positions, guarded by write protect
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			for (int c = 0; c < NUM_CHAN; c++) begin
				for (int s = 0; s < NUM_SLOT; s++) begin
					saved_q[c][s] <= NV_INIT;
				end
			end
		end else if (twiWrSaved) begin
			saved_q[exeChan][exeSlot] <= rxByte;
		end else if (xfrToSaved) begin
			saved_q[exeChan][exeSlot] <= wiper_q[exeChan];
		end else if (storeEv && wpS) begin
			saved_q[chanS][DEFAULT_SLOT] <= wiper_q[chanS];
		end
	end

	// ***********************************************
	// tap switch outputs
	// ***********************************************
	assign wiperPos = wiper_q;

	// registered one-hot tap selection per channel
	for (genvar g = 0; g < NUM_CHAN; g++) begin : g_tap
		always_ff @(posedge clk_sys) begin
			if (!nrst) begin
				tapClosed[g] <= '0;
			end else begin
				tapClosed[g] <= tapDecode(wiper_q[g]);
			end
		end
	end

endmodule // quad_pot_wiper_control
`default_nettype wire

// ==== step_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface step_if import quad_pot_pkg::*; ();
	logic stepTgl;
	logic stepUp;
	logic [CHAN_W-1:0] stepChan;
	modport src (output stepTgl, output stepUp, output stepChan);
	modport dst (input stepTgl, input stepUp, input stepChan);
endinterface
`default_nettype wire

// ==== sync_2ff.sv ====
`timescale 1ns/100ps
`default_nettype none
module sync_2ff #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// data
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] stable_q;

	// first stage is read only by the second
	always_ff @(posedge clk) begin
		if (!nrst) begin
			meta_q <= RESET_VAL;
			stable_q <= RESET_VAL;
		end else begin
			meta_q <= din;
			stable_q <= meta_q;
		end
	end

	assign dout = stable_q;

endmodule // sync_2ff
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
	$display("MISMATCH t=%0t act=%h exp=%h", $time, (a), (e)); end end
module tb import quad_pot_pkg::*;;
	// *****
	// pins and bookkeeping
	// *****
	logic clk_sys, linkClk, nrst, sclClk, sdaIn, sdaOut, sdaOe, csN, upDir, wpN, linkBusy, sdaDrvLow;
	logic [STRAP_W-1:0] strapAddr;
	logic [CHAN_W-1:0] chanSel;
	logic [NUM_CHAN-1:0][POS_W-1:0] wiperPos;
	logic [NUM_CHAN-1:0][NUM_TAPS-1:0] tapClosed;
	logic [7:0] expQ[$];
	logic [7:0] obsVal, expV, rx, adr;
	logic [POS_W-1:0] wv[NUM_CHAN];
	logic ok;
	int num_errors = 0, n_compared = 0, cycles = 0, seed;
	event resEv;
	// pull-up on the data wire, either side pulls low
	assign sdaIn = !(sdaOe || sdaDrvLow);
	quad_pot_wiper_control u_dut (.clk_sys(clk_sys), .nrst(nrst), .sclClk(sclClk), .sdaIn(sdaIn),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .strapAddr(strapAddr), .csN(csN), .upDir(upDir),
		.chanSel(chanSel), .wpN(wpN), .wiperPos(wiperPos), .tapClosed(tapClosed), .linkBusy(linkBusy));
	twi_master_model u_mst (.linkClk(linkClk), .sdaWire(sdaIn), .sclPin(sclClk), .sdaDrvLow(sdaDrvLow));
	// system and link clocks, phases unrelated
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = !clk_sys;
	end
	initial begin
		linkClk = 1'b0;
		#1.7;
		forever #3 linkClk = !linkClk;
	end
	// hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			final_report();
		end
	end
	// result watcher, oldest note first
	always @(resEv) begin
		expV = expQ.pop_front();
		`CHK(obsVal, expV)
	end
	// note the expectation, then hand over the result
	task automatic check(input logic [7:0] e, input logic [7:0] a);
		expQ.push_back(e);
		obsVal = a;
		->resEv;
		#1;
	endtask
	task automatic final_report();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// reset with one link clock pulse (a fall, then a rise) inside it, then recall check
	task automatic resetRecall();
		@(posedge clk_sys);
		nrst <= 1'b0;
		u_mst.pins(1'b0, 1'b0);
		u_mst.pins(1'b1, 1'b0);
		@(posedge clk_sys);
		nrst <= 1'b1;
		repeat (6) @(posedge clk_sys);
		for (int c = 0; c < NUM_CHAN; c++) check(NV_INIT, wiperPos[c]);
	endtask
	// address, opcode, register address, one data byte
	task automatic twi(input logic [3:0] op, input logic [3:0] ra, input logic [7:0] d);
		logic ar;
		u_mst.start();
		u_mst.byteX(adr, 1'b1, rx, ar);
		ok = !ar;
		if (ok) begin
			u_mst.byteX({op, 4'h0}, 1'b1, rx, ar);
			ok = ok && !ar;
			u_mst.byteX({4'h0, ra}, 1'b1, rx, ar);
			ok = ok && !ar;
			u_mst.byteX(d, 1'b1, rx, ar);
		end
		u_mst.stop();
	endtask
	// n steps on one channel, optional store on exit
	task automatic stepRun(input int c, input logic up, input int n, input logic store);
		@(posedge clk_sys);
		chanSel <= CHAN_W'(c);
		upDir <= up;
		@(posedge clk_sys);
		csN <= 1'b0;
		u_mst.pins(1'b0, 1'b0);
		repeat (n) begin
			u_mst.pins(1'b1, 1'b0);
			u_mst.pins(1'b0, 1'b0);
			if (up) wv[c] = (wv[c] == POS_MAX) ? wv[c] : wv[c] + POS_ONE;
			else wv[c] = (wv[c] == POS_MIN) ? wv[c] : wv[c] - POS_ONE;
		end
		// the rising edge before a store is itself one more step
		if (store) begin
			u_mst.pins(1'b1, 1'b0);
			if (up) wv[c] = (wv[c] == POS_MAX) ? wv[c] : wv[c] + POS_ONE;
			else wv[c] = (wv[c] == POS_MIN) ? wv[c] : wv[c] - POS_ONE;
		end
		@(posedge clk_sys);
		csN <= 1'b1;
		u_mst.pins(1'b1, 1'b0);
		check(wv[c], wiperPos[c]);
	endtask
	// main sequence
	initial begin
		nrst = 1'b0;
		csN = 1'b1;
		upDir = 1'b1;
		chanSel = '0;
		wpN = 1'b1;
		seed = $urandom(32'h5a82);
		strapAddr = STRAP_W'($urandom_range(7, 0));
		adr = {DEV_ID_HI, strapAddr};
		resetRecall();
		for (int c = 0; c < NUM_CHAN; c++) begin
			wv[c] = 8'($urandom);
			twi(OP_WR_WIPER, 4'(c), wv[c]);
			check(8'h01, {7'h00, ok});
			check(wv[c], wiperPos[c]);
			twi(OP_RD_WIPER, 4'(c), 8'hFF);
			check(wv[c], rx);
		end
		adr = {DEV_ID_HI, strapAddr ^ 3'h5};
		twi(OP_WR_WIPER, 4'h0, 8'h11);
		check(8'h00, {7'h00, ok});
		check(wv[0], wiperPos[0]);
		adr = {DEV_ID_HI, strapAddr};
		for (int p = 1; p >= 0; p--) begin
			@(posedge clk_sys);
			wpN <= p[0];
			twi(OP_WR_SAVED, 4'h9, p[0] ? 8'h3C : 8'hC3);
			twi(OP_RD_SAVED, 4'h9, 8'hFF);
			check(8'h3C, rx);
		end
		@(posedge clk_sys);
		wpN <= 1'b1;
		twi(OP_XFR_TO_SAVED, 4'hE, 8'hFF);
		twi(OP_WR_WIPER, 4'h2, 8'h00);
		twi(OP_XFR_TO_WIPER, 4'hE, 8'hFF);
		check(wv[2], wiperPos[2]);
		wv[2] = 8'hFE;
		twi(OP_WR_WIPER, 4'h2, wv[2]);
		stepRun(2, 1'b1, 3, 1'b1);
		wv[3] = 8'h01;
		twi(OP_WR_WIPER, 4'h3, wv[3]);
		@(posedge clk_sys);
		wpN <= 1'b0;
		stepRun(3, 1'b0, 2, 1'b1);
		stepRun(1, 1'($urandom), $urandom_range(6, 1), 1'b0);
		check(wv[0], wiperPos[0]);
		twi(OP_RD_SAVED, 4'h2, 8'hFF);
		check(8'hFF, rx);
		twi(OP_RD_SAVED, 4'h3, 8'hFF);
		check(NV_INIT, rx);
		resetRecall();
		final_report();
	end
endmodule // tb
`default_nettype wire

// ==== twi_master_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// *****
// two-wire and step master
// *****
module twi_master_model (
	// link clock
	input wire logic linkClk,
	// wire levels
	input wire logic sdaWire,
	output logic sclPin,
	output logic sdaDrvLow
);
	localparam int HOLD = 17;
	// idle bus: clock high, data released
	initial begin
		sclPin = 1'b1;
		sdaDrvLow = 1'b0;
	end
	// one half step; clock stands still between calls
	task automatic pins(input logic s, input logic d);
		@(posedge linkClk);
		sclPin <= s;
		sdaDrvLow <= d;
		repeat (HOLD) @(posedge linkClk);
	endtask
	// data moves only while clock low, held across the rise
	task automatic bitX(input logic b, output logic r);
		pins(1'b0, sdaDrvLow);
		pins(1'b0, !b);
		r = sdaWire;
		pins(1'b1, !b);
	endtask
	// eight bits msb first, then the ninth bit
	task automatic byteX(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ar);
		for (int i = 7; i >= 0; i--) bitX(tx[i], rx[i]);
		bitX(last, ar);
	endtask
	task automatic start();
		pins(1'b1, 1'b1);
	endtask
	task automatic stop();
		pins(1'b0, sdaDrvLow);
		pins(1'b0, 1'b1);
		pins(1'b1, 1'b1);
		pins(1'b1, 1'b0);
	endtask
endmodule // twi_master_model
`default_nettype wire

// ==== updown_stepper.sv ====
`timescale 1ns/100ps
`default_nettype none
module updown_stepper import quad_pot_pkg::*; (
	// link clock and reset
	input wire logic sclClk,
	input wire logic nrst,
	// up/down pins, steady around each rising link edge
	input wire logic csN,
	input wire logic upDir,
	input wire logic [CHAN_W-1:0] chanSel,
	// step events toward the system domain
	step_if.src stepPort
);

	logic stepTgl_q;
	logic stepUp_q;
	logic [CHAN_W-1:0] stepChan_q;

	// one toggle per link pulse while stepping is selected
	always_ff @(posedge sclClk) begin
		if (!nrst) begin
			stepTgl_q <= 1'b0;
		end else if (!csN) begin
			stepTgl_q <= ~stepTgl_q;
		end
	end

	// direction and channel held with the toggle, stable until the next edge
	always_ff @(posedge sclClk) begin
		if (!nrst) begin
			stepUp_q <= 1'b0;
			stepChan_q <= '0;
		end else if (!csN) begin
			stepUp_q <= upDir;
			stepChan_q <= chanSel;
		end
	end

	assign stepPort.stepTgl = stepTgl_q;
	assign stepPort.stepUp = stepUp_q;
	assign stepPort.stepChan = stepChan_q;

endmodule // updown_stepper
`default_nettype wire
